//--- core/sss_regs.vh
// Constants for the start-up and soft-start sequencer.
// Assumes a 200 MHz core clock; included by all sequencer files.
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define SSS_CLK_MHZ          200
`define SSS_MS_NS            1000000
`define SSS_CLK_NS           5
`define SSS_TICK_CYC         (`SSS_MS_NS / `SSS_CLK_NS)
`define SSS_NVM_MS           8'h05
`define SSS_INIT_ZERO_MS     8'h02

// ==========================================================================
// Register offsets
// ==========================================================================
`define SSS_REG_CTRL         4'h0
`define SSS_REG_DELAY        4'h1
`define SSS_REG_RAMP         4'h2
`define SSS_REG_MODE         4'h3
`define SSS_REG_STATUS       4'h4
`define SSS_REG_TARGET       4'h5
`define SSS_REG_VOUT         4'h6

// CTRL bits
`define SSS_CTRL_RESTORE     0
`define SSS_CTRL_OVR         1
// MODE bits
`define SSS_MODE_SHARE       0
`define SSS_MODE_ACOMP       1
`define SSS_MODE_STBY        2

// ==========================================================================
// Strap levels
// ==========================================================================
`define SSS_STRAP_LOW        2'h0
`define SSS_STRAP_OPEN       2'h1
`define SSS_STRAP_HIGH       2'h2
`define SSS_STRAP_RES        2'h3

// Minimum turn-on delays (ms)
`define SSS_MIN_DLY_A        8'h05
`define SSS_MIN_DLY_B        8'h0A
`define SSS_MIN_DLY_C        8'h0F

`endif

//--- core/sss_ms_tick.v
// Free-running millisecond tick generator.
// Assumes core_clk at the rate in sss_regs.vh.
`include "sss_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sss_ms_tick #(
  parameter integer TICK_CYC = `SSS_TICK_CYC
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clk_en,
  // Tick
  output reg         tick_q
);
  reg [31:0] cnt_q;
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q  <= 32'h0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q == TICK_CYC - 1) begin
        cnt_q  <= 32'h0;
        tick_q <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + 32'h1;
        tick_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/sss_strap_dec.v
// Strap decoders: soft-start pin and single-resistor output target.
// Assumes resistor index 0..19 (soft-start) and 0..30 (coarse pin).
`include "sss_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sss_strap_dec (
  // Soft-start pin
  input  wire [1:0]  ss_level,
  input  wire [4:0]  ss_res_idx,
  // Voltage pins
  input  wire [1:0]  vout_fine_strap_pin,
  input  wire [4:0]  vout_coarse_strap_pin,
  // Decoded values
  output reg  [7:0]  dly_ms,
  output reg  [7:0]  ramp_ms,
  output reg  [9:0]  vout_cv,
  output reg         vout_valid
);
  always @* begin
    dly_ms  = 8'h05;
    ramp_ms = 8'h02;
    case (ss_level)
      `SSS_STRAP_LOW: begin
        dly_ms  = 8'h05;
        ramp_ms = 8'h02;
      end
      `SSS_STRAP_OPEN: begin
        dly_ms  = 8'h05;
        ramp_ms = 8'h05;
      end
      `SSS_STRAP_HIGH: begin
        dly_ms  = 8'h0A;
        ramp_ms = 8'h0A;
      end
      default: begin
        case (ss_res_idx[4:2])
          3'h0: dly_ms = 8'h05;
          3'h1: dly_ms = 8'h0A;
          3'h2: dly_ms = 8'h0F;
          3'h3: dly_ms = 8'h14;
          default: dly_ms = 8'h1E;
        endcase
        case (ss_res_idx[1:0])
          2'h0: ramp_ms = 8'h02;
          2'h1: ramp_ms = 8'h05;
          2'h2: ramp_ms = 8'h0A;
          default: ramp_ms = 8'h14;
        endcase
      end
    endcase
  end

  // Target in units of 10 mV
  always @* begin
    vout_valid = (vout_fine_strap_pin == `SSS_STRAP_LOW);
    if (vout_coarse_strap_pin <= 5'h0E)
      vout_cv = 10'h03C + {2'h0, vout_coarse_strap_pin, 3'h0} - {5'h0, vout_coarse_strap_pin} * 10'h003;
    else begin
      case (vout_coarse_strap_pin)
        5'h0F: vout_cv = 10'h08C;
        5'h10: vout_cv = 10'h096;
        5'h11: vout_cv = 10'h0A0;
        5'h12: vout_cv = 10'h0AA;
        5'h13: vout_cv = 10'h0B4;
        5'h14: vout_cv = 10'h0BE;
        5'h15: vout_cv = 10'h0C8;
        5'h16: vout_cv = 10'h0D2;
        5'h17: vout_cv = 10'h0DC;
        5'h18: vout_cv = 10'h0E6;
        5'h19: vout_cv = 10'h0FA;
        5'h1A: vout_cv = 10'h12C;
        5'h1B: vout_cv = 10'h14A;
        5'h1C: vout_cv = 10'h190;
        5'h1D: vout_cv = 10'h1F4;
        default: vout_cv = 10'h226;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/sss_sequencer.v
// Start-up and soft-start sequencer top level.
// Assumes pins synchronous to core_clk; strap levels pre-digitised.
`include "sss_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer #(
  parameter integer TICK_CYC = `SSS_TICK_CYC,
  parameter [7:0]   NVM_MS   = `SSS_NVM_MS,
  parameter [7:0]   NVM_DEF_DLY  = 8'h05,
  parameter [7:0]   NVM_DEF_RAMP = 8'h02
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  input  wire        clk_en,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // Non-volatile store contents
  input  wire        nvm_valid,
  input  wire [7:0]  nvm_dly_ms,
  input  wire [7:0]  nvm_ramp_ms,
  // Strap pins
  input  wire [1:0]  ss_level,
  input  wire [4:0]  ss_res_idx,
  input  wire [1:0]  vout_fine_strap_pin,
  input  wire [4:0]  vout_coarse_strap_pin,
  // Enable and output
  input  wire        enable,
  output reg         ready_q,
  output reg         ramping_q,
  output reg         at_target_q,
  output reg  [9:0]  vout_target_q
);
  // ========================================================================
  // States
  // ========================================================================
  localparam [2:0] ST_NVM   = 3'h0;
  localparam [2:0] ST_PINS  = 3'h1;
  localparam [2:0] ST_READY = 3'h2;
  localparam [2:0] ST_DELAY = 3'h3;
  localparam [2:0] ST_RAMP  = 3'h4;
  localparam [2:0] ST_ON    = 3'h5;

  reg [2:0]  state_q;
  reg [7:0]  ms_cnt_q;
  reg [7:0]  dly_q;
  reg [7:0]  ramp_q;
  reg [7:0]  ovr_dly_q;
  reg [7:0]  ovr_ramp_q;
  reg        ovr_q;
  reg [2:0]  mode_q;
  reg [9:0]  final_q;
  reg [9:0]  step_q;
  reg        en_prev_q;
  // Ramp remainder, its running error and the captured ramp length
  reg [7:0]  rem_q;
  reg [7:0]  acc_q;
  reg [7:0]  ramp_len_q;

  wire       tick;
  wire [7:0] dec_dly;
  wire [7:0] dec_ramp;
  wire [9:0] dec_vout;
  wire       dec_vvalid;

  // Tick runs free, so the first counted tick lands 1 to TICK_CYC cycles late
  sss_ms_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .tick_q   (tick)
  );

  sss_strap_dec u_dec (
    .ss_level              (ss_level),
    .ss_res_idx            (ss_res_idx),
    .vout_fine_strap_pin   (vout_fine_strap_pin),
    .vout_coarse_strap_pin (vout_coarse_strap_pin),
    .dly_ms                (dec_dly),
    .ramp_ms               (dec_ramp),
    .vout_cv               (dec_vout),
    .vout_valid            (dec_vvalid)
  );

  // ========================================================================
  // Minimum turn-on delay by mode
  // ========================================================================
  // Auto-comp alone keeps the default minimum
  function [7:0] min_dly;
    input [2:0] m;
    reg share;
    reg acomp;
    reg stby;
    begin
      share = m[`SSS_MODE_SHARE];
      acomp = m[`SSS_MODE_ACOMP];
      stby  = m[`SSS_MODE_STBY];
      if (share && (acomp || stby))
        min_dly = `SSS_MIN_DLY_C;
      else if (stby)
        min_dly = `SSS_MIN_DLY_B;
      else
        min_dly = `SSS_MIN_DLY_A;
    end
  endfunction

  // Whole part of the ramp step; the remainder is spread by ramp_rem
  function [9:0] ramp_step;
    input [9:0] tgt;
    input [7:0] ms;
    begin
      if (ms == 8'h00)
        ramp_step = tgt;
      else
        ramp_step = tgt / {2'h0, ms};
    end
  endfunction

  // Remainder is below ms, so eight bits always hold it
  function [7:0] ramp_rem;
    input [9:0] tgt;
    input [7:0] ms;
    reg   [9:0] r;
    begin
      if (ms == 8'h00)
        r = 10'h000;
      else
        r = tgt % {2'h0, ms};
      ramp_rem = r[7:0];
    end
  endfunction

  // ========================================================================
  // Effective timings
  // ========================================================================
  wire [7:0] prog_dly  = ovr_q ? ovr_dly_q : dly_q;
  wire [7:0] prog_ramp = ovr_q ? ovr_ramp_q : ramp_q;
  wire [7:0] min_now   = min_dly(mode_q);
  wire       zero_dly  = (prog_dly == 8'h00);
  // Zero delay still waits out internal initialisation after enable
  wire [7:0] eff_dly   = zero_dly ? `SSS_INIT_ZERO_MS :
                         (prog_dly < min_now) ? min_now :
                         prog_dly;
  // Bus access during initialisation is dropped, never stalled
  wire       busy      = (state_q == ST_NVM) || (state_q == ST_PINS);
  wire       bus_ok    = !busy;
  wire       restore   = reg_wr && bus_ok && (reg_addr == `SSS_REG_CTRL) &&
                         reg_wdata[`SSS_CTRL_RESTORE];
  wire       en_rise   = enable && !en_prev_q;
  // Error accumulator: the last step lands exactly on the final tick
  wire [8:0] acc_sum   = {1'b0, acc_q} + {1'b0, rem_q};
  wire [8:0] acc_left  = acc_sum - {1'b0, ramp_len_q};
  wire       carry     = (ramp_len_q != 8'h00) && (acc_sum >= {1'b0, ramp_len_q});
  wire [9:0] vout_next = vout_target_q + step_q + {9'h000, carry};

  // ========================================================================
  // Sequencer
  // ========================================================================
  always @(posedge core_clk) begin
    if (rst) begin
      state_q       <= ST_NVM;
      ms_cnt_q      <= 8'h00;
      dly_q         <= 8'h00;
      ramp_q        <= 8'h00;
      final_q       <= 10'h000;
      step_q        <= 10'h000;
      rem_q         <= 8'h00;
      acc_q         <= 8'h00;
      ramp_len_q    <= 8'h00;
      vout_target_q <= 10'h000;
      ready_q       <= 1'b0;
      ramping_q     <= 1'b0;
      at_target_q   <= 1'b0;
      en_prev_q     <= 1'b0;
    end else if (clk_en) begin
      // Edge memory held low while busy so a tied-high enable counts on ready
      en_prev_q <= busy ? 1'b0 : enable;
      if (restore) begin
        state_q       <= ST_NVM;
        ms_cnt_q      <= 8'h00;
        ready_q       <= 1'b0;
        ramping_q     <= 1'b0;
        at_target_q   <= 1'b0;
        vout_target_q <= 10'h000;
      end else begin
        case (state_q)
          ST_NVM: begin
            if (tick) begin
              ms_cnt_q <= ms_cnt_q + 8'h01;
            end
            if (ms_cnt_q == NVM_MS) begin
              dly_q    <= nvm_valid ? nvm_dly_ms : NVM_DEF_DLY;
              ramp_q   <= nvm_valid ? nvm_ramp_ms : NVM_DEF_RAMP;
              state_q  <= ST_PINS;
            end
          end
          ST_PINS: begin
            // Pins win only when memory had nothing stored
            if (!nvm_valid) begin
              dly_q  <= dec_dly;
              ramp_q <= dec_ramp;
            end
            final_q <= dec_vvalid ? dec_vout : 10'h03C;
            ready_q <= 1'b1;
            state_q <= ST_READY;
          end
          ST_READY: begin
            if (en_rise) begin
              ms_cnt_q <= 8'h00;
              state_q  <= ST_DELAY;
            end
          end
          ST_DELAY: begin
            if (!enable) begin
              state_q <= ST_READY;
            end else if (ms_cnt_q >= eff_dly) begin
              step_q     <= ramp_step(final_q, prog_ramp);
              rem_q      <= ramp_rem(final_q, prog_ramp);
              acc_q      <= 8'h00;
              // Captured so a bus write cannot bend a ramp in flight
              ramp_len_q <= prog_ramp;
              ms_cnt_q  <= 8'h00;
              ramping_q <= 1'b1;
              state_q   <= ST_RAMP;
            end else if (tick) begin
              ms_cnt_q <= ms_cnt_q + 8'h01;
            end
          end
          ST_RAMP: begin
            if (!enable) begin
              ramping_q     <= 1'b0;
              vout_target_q <= 10'h000;
              state_q       <= ST_READY;
            end else if (tick || (ramp_len_q == 8'h00)) begin
              // Only ever moves up; clamps at final value
              if (vout_next >= final_q || vout_next < vout_target_q) begin
                vout_target_q <= final_q;
                ramping_q     <= 1'b0;
                at_target_q   <= 1'b1;
                state_q       <= ST_ON;
              end else begin
                vout_target_q <= vout_next;
                acc_q         <= carry ? acc_left[7:0] : acc_sum[7:0];
              end
            end
          end
          // No soft-stop: dropping enable clears the target at once
          ST_ON: begin
            if (!enable) begin
              at_target_q   <= 1'b0;
              vout_target_q <= 10'h000;
              state_q       <= ST_READY;
            end
          end
          default: state_q <= ST_NVM;
        endcase
      end
    end
  end

  // ========================================================================
  // Register writes
  // ========================================================================
  always @(posedge core_clk) begin
    if (rst) begin
      ovr_q      <= 1'b0;
      ovr_dly_q  <= 8'h00;
      ovr_ramp_q <= 8'h00;
      mode_q     <= 3'h0;
    end else if (clk_en && reg_wr && bus_ok) begin
      // A restore write with bit 1 low also drops the override
      if (reg_addr == `SSS_REG_CTRL) begin
        ovr_q <= reg_wdata[`SSS_CTRL_OVR];
      end else if (reg_addr == `SSS_REG_DELAY) begin
        ovr_dly_q <= reg_wdata[7:0];
      end else if (reg_addr == `SSS_REG_RAMP) begin
        ovr_ramp_q <= reg_wdata[7:0];
      end else if (reg_addr == `SSS_REG_MODE) begin
        mode_q <= reg_wdata[2:0];
      end
    end
  end

  // ========================================================================
  // Register reads: one cycle later, zero when busy or unmapped
  // ========================================================================
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= 16'h0000;
      if (reg_rd && bus_ok) begin
        if (reg_addr == `SSS_REG_CTRL)
          reg_rdata <= {14'h0000, ovr_q, 1'b0};
        else if (reg_addr == `SSS_REG_DELAY)
          reg_rdata <= {8'h00, prog_dly};
        else if (reg_addr == `SSS_REG_RAMP)
          reg_rdata <= {8'h00, prog_ramp};
        else if (reg_addr == `SSS_REG_MODE)
          reg_rdata <= {13'h0000, mode_q};
        else if (reg_addr == `SSS_REG_STATUS)
          reg_rdata <= {8'h00, eff_dly[4:0], state_q};
        else if (reg_addr == `SSS_REG_TARGET)
          reg_rdata <= {6'h00, final_q};
        else if (reg_addr == `SSS_REG_VOUT)
          reg_rdata <= {6'h00, vout_target_q};
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/sss_seq_chk_properties.sv
// Checker for the sequencer: init length, bus quiet time, ramp order.
// Sees only the top-level ports; bound to sss_sequencer below.
`timescale 1ns/1ps
`default_nettype none
module sss_seq_chk #(
  parameter integer TICK_CYC = 20,
  parameter [7:0]   NVM_MS   = 8'h05
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Bus and enable
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        enable,
  // Sequencer outputs
  input wire logic        ready_q,
  input wire logic        ramping_q,
  input wire logic        at_target_q,
  input wire logic [9:0]  vout_target_q
);
  // Tick phase is free, so allow two spare ticks on the memory check
  localparam int INIT_MAX = (NVM_MS + 2) * TICK_CYC;
  logic [15:0] en_cyc_q;
  logic [15:0] en_cyc_d;

  // ==========================================================================
  // Cycles spent with enable high
  // ==========================================================================
  always_comb begin
    en_cyc_d = enable ? en_cyc_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_cyc_q <= 16'h0000;
    end else begin
      en_cyc_q <= en_cyc_d;
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_init_quiet;
    !ready_q [*8];
  endsequence
  sequence s_ready_soon;
    ##[1:INIT_MAX] ready_q;
  endsequence
  property p_init_quiet;
    $fell(rst) |-> s_init_quiet;
  endproperty
  property p_init_bound;
    $fell(rst) |-> s_ready_soon;
  endproperty
  property p_restore;
    $fell(ready_q) |-> s_ready_soon;
  endproperty
  property p_busy_reads;
    reg_rd && !ready_q |=> reg_rdata == 16'h0000;
  endproperty
  property p_rdata_slot;
    reg_rdata != 16'h0000 |-> $past(reg_rd);
  endproperty
  property p_ramp_ready;
    ramping_q |-> ready_q;
  endproperty
  property p_ramp_enable;
    $rose(ramping_q) |-> enable && en_cyc_q >= TICK_CYC;
  endproperty
  property p_monotonic;
    ramping_q && $past(ramping_q) |-> vout_target_q >= $past(vout_target_q);
  endproperty
  property p_disable;
    $fell(enable) |-> ##[1:4] vout_target_q == 10'h000;
  endproperty
  property p_target_hold;
    at_target_q && $past(at_target_q) |-> $stable(vout_target_q);
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("ready too early");
  a_init_bound: assert property (p_init_bound) else $error("init too long");
  a_restore: assert property (p_restore) else $error("restore hung");
  a_busy_reads: assert property (p_busy_reads) else $error("bus served in init");
  a_rdata_slot: assert property (p_rdata_slot) else $error("stray read data");
  a_ramp_ready: assert property (p_ramp_ready) else $error("ramp before ready");
  a_ramp_enable: assert property (p_ramp_enable) else $error("ramp too soon");
  a_monotonic: assert property (p_monotonic) else $error("ramp stepped back");
  a_disable: assert property (p_disable) else $error("output kept on");
  a_target_hold: assert property (p_target_hold) else $error("target moved at rest");
endmodule

bind sss_sequencer sss_seq_chk #(.TICK_CYC(TICK_CYC), .NVM_MS(NVM_MS)) u_chk (
  .core_clk(core_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .enable(enable), .ready_q(ready_q), .ramping_q(ramping_q),
  .at_target_q(at_target_q), .vout_target_q(vout_target_q)
);
`default_nettype wire

//--- dv/sss_host_model.sv
// Host controller model: register port master and enable driver.
// Assumes the core clock; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module sss_host_model (
  // Clock
  input wire logic         core_clk,
  // Register port
  output logic [3:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input wire logic [15:0]  reg_rdata,
  // Enable pin, high from power-up to model a tied pin
  output logic             enable
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    enable = 1'b1;
  end
  // Custom timings reach the block only through this write
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // No external sync clock here, so enable never waits on one
  task automatic set_en(input logic v);
    @(posedge core_clk);
    enable <= v;
  endtask
endmodule
`default_nettype wire

//--- dv/sss_sequencer_tb_top.sv
// Bench for the sequencer: tied enable, strap decode, mode minimums.
// Assumes core/ on the include path and a short tick for run time.
`include "sss_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sss_sequencer_tb_top;
  localparam integer T = 20;
  logic        core_clk;
  logic        rst;
  logic        clk_en;
  logic        nvm_valid;
  logic [7:0]  nvm_dly_ms;
  logic [7:0]  nvm_ramp_ms;
  logic [1:0]  ss_level;
  logic [4:0]  ss_res_idx;
  logic [1:0]  vout_fine_strap_pin;
  logic [4:0]  vout_coarse_strap_pin;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        enable;
  logic        ready_q;
  logic        ramping_q;
  logic        at_target_q;
  logic [9:0]  vout_target_q;
  integer      fail_count;
  integer      samples_checked;
  logic [15:0] rv;
  int          d;
  int          r;

  sss_sequencer #(.TICK_CYC(T), .NVM_MS(8'h05)) dut (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .nvm_valid(nvm_valid), .nvm_dly_ms(nvm_dly_ms), .nvm_ramp_ms(nvm_ramp_ms),
    .ss_level(ss_level), .ss_res_idx(ss_res_idx), .vout_fine_strap_pin(vout_fine_strap_pin),
    .vout_coarse_strap_pin(vout_coarse_strap_pin), .enable(enable), .ready_q(ready_q),
    .ramping_q(ramping_q), .at_target_q(at_target_q), .vout_target_q(vout_target_q)
  );
  sss_host_model host (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable(enable)
  );

  always #2.5 core_clk = ~core_clk;

  // ==========================================================================
  // Shared checks and waits
  // ==========================================================================
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int lo, input int hi, input int got);
    samples_checked = samples_checked + 1;
    if (got < lo || got > hi) begin
      fail_count = fail_count + 1;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // sel 0: ready, 1: ramp started or done, 2: at target
  task automatic wait_for(input int sel, output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n = n + 1;
    end while (!(sel == 0 ? ready_q === 1'b1 : sel == 1 ?
                 (ramping_q === 1'b1 || at_target_q === 1'b1) : at_target_q === 1'b1)
               && n < 3000);
    if (n >= 3000) chk("wait", 16'h0001, 16'h0000);
  endtask
  task automatic restore();
    host.wr(`SSS_REG_CTRL, 16'h0001);
    repeat (3) @(posedge core_clk);
    wait_for(0, d);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_tied();
    host.rd(`SSS_REG_DELAY, rv);
    chk("busy read", 16'h0000, rv);
    wait_for(0, d);
    rng("init cycles", 5 * T - 4, 10 * T, d + 2);
    wait_for(1, d);
    rng("tied delay", 4 * T, 5 * T + 8, d);
    wait_for(2, r);
    rng("strap ramp", T, 2 * T + 8, r);
    chk("target", 16'h0064, {6'h00, vout_target_q});
    clk_en <= 1'b0;
    host.set_en(1'b0);
    repeat (3) @(posedge core_clk);
    chk("frozen", 16'h0064, {6'h00, vout_target_q});
    clk_en <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("off", 16'h0000, {6'h00, vout_target_q});
    $display("test tied_enable done");
  endtask

  task automatic t_straps();
    logic [1:0] lv [0:4] = '{`SSS_STRAP_OPEN, `SSS_STRAP_HIGH, `SSS_STRAP_RES,
                             `SSS_STRAP_RES, `SSS_STRAP_RES};
    logic [4:0] ix [0:4] = '{5'h00, 5'h00, 5'h00, 5'h09, 5'h13};
    logic [7:0] ed [0:4] = '{8'h05, 8'h0A, 8'h05, 8'h0F, 8'h1E};
    logic [7:0] er [0:4] = '{8'h05, 8'h0A, 8'h02, 8'h05, 8'h14};
    vout_coarse_strap_pin <= 5'h1E;
    for (int i = 0; i < 5; i++) begin
      ss_level <= lv[i];
      ss_res_idx <= ix[i];
      restore();
      host.rd(`SSS_REG_DELAY, rv);
      chk("strap delay", {8'h00, ed[i]}, rv);
      host.rd(`SSS_REG_RAMP, rv);
      chk("strap ramp", {8'h00, er[i]}, rv);
    end
    ss_res_idx <= 5'h00;
    host.rd(`SSS_REG_DELAY, rv);
    chk("held delay", 16'h001E, rv);
    host.rd(4'hF, rv);
    chk("unmapped", 16'h0000, rv);
    nvm_valid <= 1'b1;
    restore();
    host.rd(`SSS_REG_DELAY, rv);
    chk("stored delay", 16'h0014, rv);
    nvm_valid <= 1'b0;
    $display("test strap_decode done");
  endtask

  task automatic t_modes();
    logic [2:0] md [0:6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0};
    int ed [0:6] = '{5, 5, 10, 15, 15, 12, 2};
    host.wr(`SSS_REG_CTRL, 16'h0002);
    for (int i = 0; i < 7; i++) begin
      host.wr(`SSS_REG_MODE, {13'h0000, md[i]});
      host.wr(`SSS_REG_DELAY, (i == 5) ? 16'h000C : (i == 6) ? 16'h0000 : 16'h0001);
      host.wr(`SSS_REG_RAMP, (i == 5) ? 16'h0000 : 16'h0003);
      host.set_en(1'b1);
      wait_for(1, d);
      rng("mode delay", (ed[i] - 1) * T, ed[i] * T + 8, d);
      wait_for(2, r);
      if (i == 5) rng("step ramp", 0, 2, r);
      else rng("ramp time", 2 * T, 3 * T + 8, r);
      chk("target", 16'h0226, {6'h00, vout_target_q});
      host.set_en(1'b0);
      repeat (6) @(posedge core_clk);
      chk("off", 16'h0000, {6'h00, vout_target_q});
    end
    $display("test mode_minimum done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    fail_count = 0;
    samples_checked = 0;
    core_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    nvm_valid = 1'b0;
    nvm_dly_ms = 8'h14;
    nvm_ramp_ms = 8'h0A;
    ss_level = `SSS_STRAP_LOW;
    ss_res_idx = 5'h00;
    vout_fine_strap_pin = 2'h0;
    vout_coarse_strap_pin = 5'h08;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_tied();
    t_straps();
    t_modes();
    end_of_test();
  end
  // About fifteen times the expected run
  initial begin
    #200000;
    fail_count = fail_count + 1;
    end_of_test();
  end
endmodule
`default_nettype wire
